// ---- rtl/vdrv_pkg.sv ----
// Constants shared by the vertical driver level-select logic.
`default_nettype none
package vdrv_pkg;
   // Two-bit level codes presented to the high-voltage stage.
   localparam logic [1:0] LEVEL_LOW = 2'h0;
   localparam logic [1:0] LEVEL_MID = 2'h1;
   localparam logic [1:0] LEVEL_HIGH = 2'h2;
   // Configuration register indices on the write/read port.
   localparam logic [1:0] ADDR_SUB_SRC = 2'h0;
   localparam logic [1:0] ADDR_MECH_SRC = 2'h1;
   localparam logic [1:0] ADDR_STROBE_SRC = 2'h2;
   localparam logic [1:0] ADDR_BIAS_SRC = 2'h3;
   // Reset values.
   localparam logic [3:0] SUB_SRC_RESET = 4'h0;
   localparam logic [3:0] SHUT_SRC_RESET = 4'hF;
   // Substrate mid/low control source codes.
   localparam logic [3:0] SUB_VP6 = 4'h0;
   localparam logic [3:0] SUB_VP8 = 4'h1;
   localparam logic [3:0] SUB_VP9 = 4'h2;
   localparam logic [3:0] SUB_VP10 = 4'h3;
   localparam logic [3:0] SUB_SG5 = 4'h4;
   localparam logic [3:0] SUB_SG6 = 4'h5;
   localparam logic [3:0] SUB_SG7 = 4'h6;
   localparam logic [3:0] SUB_SG8 = 4'h7;
   localparam logic [3:0] SUB_SG2 = 4'h8;
   localparam logic [3:0] SUB_SG3 = 4'h9;
   localparam logic [3:0] SUB_SG4 = 4'hA;
   localparam logic [3:0] SUB_SG1 = 4'hB;
   localparam logic [3:0] SUB_VP13 = 4'hC;
   localparam logic [3:0] SUB_BIAS = 4'hD;
   localparam logic [3:0] SUB_MECH = 4'hE;
   localparam logic [3:0] SUB_STROBE = 4'hF;
   // Shutter pin source codes; codes above SH_X_S0_S2 drive the pin low.
   localparam logic [3:0] SH_S0 = 4'h0;
   localparam logic [3:0] SH_S1 = 4'h1;
   localparam logic [3:0] SH_S2 = 4'h2;
   localparam logic [3:0] SH_S3 = 4'h3;
   localparam logic [3:0] SH_B0 = 4'h4;
   localparam logic [3:0] SH_B1 = 4'h5;
   localparam logic [3:0] SH_X_S0_B0 = 4'h6;
   localparam logic [3:0] SH_X_S0_B1 = 4'h7;
   localparam logic [3:0] SH_X_S0_S1 = 4'h8;
   localparam logic [3:0] SH_X_S0_S2 = 4'h9;
endpackage
`default_nettype wire

// ---- rtl/vdriver_level_select.sv ----
// Level-select logic of the vertical, substrate and shutter drivers.
//
// Contract
// - Thirteen phases, eight gate pulses, one substrate drive feed the driver, merged per channel.
// - Channel 1: high if vphase_1 and sg_pulse_1 low, mid if gate high, low if phase high.
// - Channel 3: same three-level rule using vphase_3 with sg_pulse_3.
// - Channels 5a and 5b use vphase_5 with sg_pulse_5 and sg_pulse_6.
// - Channels 7a and 7b use vphase_7 with sg_pulse_7 and sg_pulse_8.
// - Channel 11 uses vphase_11 with sg_pulse_2 under the three-level rule.
// - Channel 12 uses vphase_12 with sg_pulse_4 under the three-level rule.
// - Channels 2,4,6,8,9,10,13: mid when own phase low, low when high.
// - Substrate out high when drive low; else mid if level control low, low if high.
// - Substrate level control comes from a sixteen-way selector with fixed source codes.
// - The substrate source selector resets to code zero, picking vphase_6.
// - Four shutter and two bias pulses are assignable to the three shutter pins.
// - Pins may also take XORs of shutter_pulse_0 with four other pulses.
// - Three shutter modes place substrate pulses; placement arrives on substrate_clock_drive.
// - Normal mode pulses once per line; count per field sets exposure.
`default_nettype none
module vdriver_level_select (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Vertical phases from the timing generator
   input wire logic vphase_1,
   input wire logic vphase_2,
   input wire logic vphase_3,
   input wire logic vphase_4,
   input wire logic vphase_5,
   input wire logic vphase_6,
   input wire logic vphase_7,
   input wire logic vphase_8,
   input wire logic vphase_9,
   input wire logic vphase_10,
   input wire logic vphase_11,
   input wire logic vphase_12,
   input wire logic vphase_13,
   // Sensor-gate pulses
   input wire logic sg_pulse_1,
   input wire logic sg_pulse_2,
   input wire logic sg_pulse_3,
   input wire logic sg_pulse_4,
   input wire logic sg_pulse_5,
   input wire logic sg_pulse_6,
   input wire logic sg_pulse_7,
   input wire logic sg_pulse_8,
   // Substrate drive and shutter pulses
   input wire logic substrate_clock_drive,
   input wire logic shutter_pulse_0,
   input wire logic shutter_pulse_1,
   input wire logic shutter_pulse_2,
   input wire logic shutter_pulse_3,
   input wire logic bias_pulse_0,
   input wire logic bias_pulse_1,
   // Configuration port
   input wire logic reg_wr_en,
   input wire logic [1:0] reg_addr,
   input wire logic [3:0] reg_wr_data,
   output logic [3:0] reg_rd_data,
   // Vertical channel level codes
   output logic [1:0] drv_out_1,
   output logic [1:0] drv_out_2,
   output logic [1:0] drv_out_3,
   output logic [1:0] drv_out_4,
   output logic [1:0] drv_out_5a,
   output logic [1:0] drv_out_5b,
   output logic [1:0] drv_out_6,
   output logic [1:0] drv_out_7a,
   output logic [1:0] drv_out_7b,
   output logic [1:0] drv_out_8,
   output logic [1:0] drv_out_9,
   output logic [1:0] drv_out_10,
   output logic [1:0] drv_out_11,
   output logic [1:0] drv_out_12,
   output logic [1:0] drv_out_13,
   // Substrate and shutter outputs
   output logic [1:0] substrate_clock_out,
   output logic substrate_level_ctl,
   output logic mech_shutter_out,
   output logic strobe_out,
   output logic substrate_bias_sel
);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release and level functions

   logic rst_meta;
   logic rst_n;
   logic [3:0] substrate_level_source;
   logic [3:0] mech_src;
   logic [3:0] strobe_src;
   logic [3:0] bias_src;
   logic next_mech;
   logic next_strobe;
   logic next_bias;
   logic next_level_ctl;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end // reset release
   // A high phase always wins, so a gate pulse can only pull a low-phase channel from high down to mid.
   function automatic logic [1:0] three_level(input logic phase, input logic gate);
      three_level = phase ? vdrv_pkg::LEVEL_LOW : (gate ? vdrv_pkg::LEVEL_MID : vdrv_pkg::LEVEL_HIGH);
   endfunction
   function automatic logic [1:0] two_level(input logic phase);
      two_level = phase ? vdrv_pkg::LEVEL_LOW : vdrv_pkg::LEVEL_MID;
   endfunction
   function automatic logic shutter_source(input logic [3:0] sel, input logic [3:0] sh, input logic [1:0] b);
      case (sel)
         vdrv_pkg::SH_S0: shutter_source = sh[0];
         vdrv_pkg::SH_S1: shutter_source = sh[1];
         vdrv_pkg::SH_S2: shutter_source = sh[2];
         vdrv_pkg::SH_S3: shutter_source = sh[3];
         vdrv_pkg::SH_B0: shutter_source = b[0];
         vdrv_pkg::SH_B1: shutter_source = b[1];
         vdrv_pkg::SH_X_S0_B0: shutter_source = sh[0] ^ b[0];
         vdrv_pkg::SH_X_S0_B1: shutter_source = sh[0] ^ b[1];
         vdrv_pkg::SH_X_S0_S1: shutter_source = sh[0] ^ sh[1];
         vdrv_pkg::SH_X_S0_S2: shutter_source = sh[0] ^ sh[2];
         default: shutter_source = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         substrate_level_source <= vdrv_pkg::SUB_SRC_RESET;
         mech_src <= vdrv_pkg::SHUT_SRC_RESET;
         strobe_src <= vdrv_pkg::SHUT_SRC_RESET;
         bias_src <= vdrv_pkg::SHUT_SRC_RESET;
      end else if (reg_wr_en) begin
         case (reg_addr)
            vdrv_pkg::ADDR_SUB_SRC: substrate_level_source <= reg_wr_data;
            vdrv_pkg::ADDR_MECH_SRC: mech_src <= reg_wr_data;
            vdrv_pkg::ADDR_STROBE_SRC: strobe_src <= reg_wr_data;
            vdrv_pkg::ADDR_BIAS_SRC: bias_src <= reg_wr_data;
            default: substrate_level_source <= substrate_level_source;
         endcase
      end
   end // configuration registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rd_data <= 4'h0;
      end else begin
         case (reg_addr)
            vdrv_pkg::ADDR_SUB_SRC: reg_rd_data <= substrate_level_source;
            vdrv_pkg::ADDR_MECH_SRC: reg_rd_data <= mech_src;
            vdrv_pkg::ADDR_STROBE_SRC: reg_rd_data <= strobe_src;
            vdrv_pkg::ADDR_BIAS_SRC: reg_rd_data <= bias_src;
            default: reg_rd_data <= 4'h0;
         endcase
      end
   end // read-back
   ////////////////////////////////////////////////////////////////////////////////
   // Vertical channels
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drv_out_1 <= vdrv_pkg::LEVEL_LOW;
         drv_out_2 <= vdrv_pkg::LEVEL_LOW;
         drv_out_3 <= vdrv_pkg::LEVEL_LOW;
         drv_out_4 <= vdrv_pkg::LEVEL_LOW;
         drv_out_5a <= vdrv_pkg::LEVEL_LOW;
         drv_out_5b <= vdrv_pkg::LEVEL_LOW;
         drv_out_6 <= vdrv_pkg::LEVEL_LOW;
         drv_out_7a <= vdrv_pkg::LEVEL_LOW;
         drv_out_7b <= vdrv_pkg::LEVEL_LOW;
         drv_out_8 <= vdrv_pkg::LEVEL_LOW;
         drv_out_9 <= vdrv_pkg::LEVEL_LOW;
         drv_out_10 <= vdrv_pkg::LEVEL_LOW;
         drv_out_11 <= vdrv_pkg::LEVEL_LOW;
         drv_out_12 <= vdrv_pkg::LEVEL_LOW;
         drv_out_13 <= vdrv_pkg::LEVEL_LOW;
      end else begin
         drv_out_1 <= three_level(vphase_1, sg_pulse_1);
         drv_out_3 <= three_level(vphase_3, sg_pulse_3);
         drv_out_5a <= three_level(vphase_5, sg_pulse_5);
         drv_out_5b <= three_level(vphase_5, sg_pulse_6);
         drv_out_7a <= three_level(vphase_7, sg_pulse_7);
         drv_out_7b <= three_level(vphase_7, sg_pulse_8);
         drv_out_11 <= three_level(vphase_11, sg_pulse_2);
         drv_out_12 <= three_level(vphase_12, sg_pulse_4);
         drv_out_2 <= two_level(vphase_2);
         drv_out_4 <= two_level(vphase_4);
         drv_out_6 <= two_level(vphase_6);
         drv_out_8 <= two_level(vphase_8);
         drv_out_9 <= two_level(vphase_9);
         drv_out_10 <= two_level(vphase_10);
         drv_out_13 <= two_level(vphase_13);
      end
   end // vertical channels
   ////////////////////////////////////////////////////////////////////////////////
   // Shutter pins and substrate buffer
   always_comb begin
      next_mech = shutter_source(mech_src, {shutter_pulse_3, shutter_pulse_2, shutter_pulse_1, shutter_pulse_0},
         {bias_pulse_1, bias_pulse_0});
      next_strobe = shutter_source(strobe_src, {shutter_pulse_3, shutter_pulse_2, shutter_pulse_1, shutter_pulse_0},
         {bias_pulse_1, bias_pulse_0});
      next_bias = shutter_source(bias_src, {shutter_pulse_3, shutter_pulse_2, shutter_pulse_1, shutter_pulse_0},
         {bias_pulse_1, bias_pulse_0});
   end
   // The selector takes the pin values of this cycle so the level control lines up with the pins.
   always_comb begin
      case (substrate_level_source)
         vdrv_pkg::SUB_VP6: next_level_ctl = vphase_6;
         vdrv_pkg::SUB_VP8: next_level_ctl = vphase_8;
         vdrv_pkg::SUB_VP9: next_level_ctl = vphase_9;
         vdrv_pkg::SUB_VP10: next_level_ctl = vphase_10;
         vdrv_pkg::SUB_SG5: next_level_ctl = sg_pulse_5;
         vdrv_pkg::SUB_SG6: next_level_ctl = sg_pulse_6;
         vdrv_pkg::SUB_SG7: next_level_ctl = sg_pulse_7;
         vdrv_pkg::SUB_SG8: next_level_ctl = sg_pulse_8;
         vdrv_pkg::SUB_SG2: next_level_ctl = sg_pulse_2;
         vdrv_pkg::SUB_SG3: next_level_ctl = sg_pulse_3;
         vdrv_pkg::SUB_SG4: next_level_ctl = sg_pulse_4;
         vdrv_pkg::SUB_SG1: next_level_ctl = sg_pulse_1;
         vdrv_pkg::SUB_VP13: next_level_ctl = vphase_13;
         vdrv_pkg::SUB_BIAS: next_level_ctl = next_bias;
         vdrv_pkg::SUB_MECH: next_level_ctl = next_mech;
         vdrv_pkg::SUB_STROBE: next_level_ctl = next_strobe;
         default: next_level_ctl = 1'b0;
      endcase
   end

   // Shutter mode timing lives upstream; this stage only turns the drive into levels.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         substrate_clock_out <= vdrv_pkg::LEVEL_HIGH;
         substrate_level_ctl <= 1'b0;
         mech_shutter_out <= 1'b0;
         strobe_out <= 1'b0;
         substrate_bias_sel <= 1'b0;
      end else begin
         if (!substrate_clock_drive) begin
            substrate_clock_out <= vdrv_pkg::LEVEL_HIGH;
         end else begin
            substrate_clock_out <= next_level_ctl ? vdrv_pkg::LEVEL_LOW : vdrv_pkg::LEVEL_MID;
         end
         substrate_level_ctl <= next_level_ctl;
         mech_shutter_out <= next_mech;
         strobe_out <= next_strobe;
         substrate_bias_sel <= next_bias;
      end
   end // substrate and shutter outputs
   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_src_zero_written;
      reg_wr_en && reg_addr == vdrv_pkg::ADDR_SUB_SRC && reg_wr_data == vdrv_pkg::SUB_VP6;
   endsequence
   sequence s_follows_vp6;
      substrate_level_ctl == $past(vphase_6);
   endsequence
   a_ch1_three_level: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> drv_out_1 == ($past(vphase_1) ? 2'h0 : ($past(sg_pulse_1) ? 2'h1 : 2'h2)))
      else $error("channel 1 level wrong");
   a_ch3_three_level: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(!vphase_3 && sg_pulse_3) |-> drv_out_3 == vdrv_pkg::LEVEL_MID)
      else $error("channel 3 mid level wrong");
   a_ch5_pair_split: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(!vphase_5 && sg_pulse_5 != sg_pulse_6) |-> drv_out_5a != drv_out_5b)
      else $error("channel 5 pair not split by gates");
   a_ch7_phase_low: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(vphase_7) |-> drv_out_7a == vdrv_pkg::LEVEL_LOW && drv_out_7b == vdrv_pkg::LEVEL_LOW)
      else $error("channel 7 not low with phase high");
   a_ch11_gate_two: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(!vphase_11) |-> drv_out_11 == ($past(sg_pulse_2) ? 2'h1 : 2'h2))
      else $error("channel 11 gate pairing wrong");
   a_ch12_gate_four: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(!vphase_12) |-> drv_out_12 == ($past(sg_pulse_4) ? 2'h1 : 2'h2))
      else $error("channel 12 gate pairing wrong");
   a_two_level_ch: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) |-> drv_out_13 == ($past(vphase_13) ? 2'h0 : 2'h1) && drv_out_2 != 2'h2)
      else $error("two-level channel wrong");
   a_sub_level_map: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(substrate_clock_drive) |-> substrate_clock_out == (substrate_level_ctl ? 2'h0 : 2'h1))
      else $error("substrate level does not follow control");
   a_sub_drive_high: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(!substrate_clock_drive) |-> substrate_clock_out == vdrv_pkg::LEVEL_HIGH)
      else $error("substrate not high with drive low");
   a_sub_src_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      s_src_zero_written ##1 !(reg_wr_en && reg_addr == vdrv_pkg::ADDR_SUB_SRC) |-> ##1 s_follows_vp6)
      else $error("code zero does not select vphase_6");
   a_src_reset_zero: assert property (@(posedge mclk)
      $rose(rst_n) |-> substrate_level_source == 4'h0)
      else $error("selector not zero after reset");
   a_mech_xor: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(mech_src) == vdrv_pkg::SH_X_S0_B0 |->
      mech_shutter_out == ($past(shutter_pulse_0) ^ $past(bias_pulse_0)))
      else $error("shutter xor combination wrong");

endmodule // vdriver_level_select
`default_nettype wire

// ---- test/ccd_sensor_model.sv ----
// Behavioural model of the sensor side that watches every level code it receives.
`default_nettype none
module ccd_sensor_model (
   // Clock
   input wire logic mclk,
   // Level codes from the driver; index 15 is the substrate
   input wire logic [1:0] codes [0:15],
   // Count of codes the high-voltage stage cannot produce
   output var int bad_codes
);
   timeunit 1ns;
   timeprecision 1ns;
   initial bad_codes = 0;
   // The sensor knows three levels only; an unused code would leave a gate floating.
   always @(negedge mclk) begin
      for (int i = 0; i < 16; i++) begin
         if (codes[i] === 2'h3) begin
            bad_codes = bad_codes + 1;
         end
      end
   end
endmodule // ccd_sensor_model
`default_nettype wire

// ---- test/vdriver_level_select_tb.sv ----
// Self-checking testbench of the vertical driver level-select block.
`default_nettype none
module vdriver_level_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [13:1] vp = '0;
   logic [8:1] sg = '0;
   logic [3:0] sp = '0;
   logic [1:0] bp = '0;
   logic sub_drv = 1'b0;
   logic wr_en = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [3:0] wdata = 4'h0;
   logic [3:0] rdata;
   logic [1:0] d [0:14];
   logic [1:0] sub_out;
   logic sub_ctl;
   logic mech;
   logic strobe;
   logic bias_sel;
   logic [1:0] codes [0:15];
   int bad_codes;
   int n_errors = 0;
   int num_checks = 0;
   // Channel order: 1,2,3,4,5a,5b,6,7a,7b,8,9,10,11,12,13; gate 0 marks a two-level channel.
   int ph_of [0:14] = '{1, 2, 3, 4, 5, 5, 6, 7, 7, 8, 9, 10, 11, 12, 13};
   int gate_of [0:14] = '{1, 0, 3, 0, 5, 6, 0, 7, 8, 0, 0, 0, 2, 4, 0};
   int sub_ph [0:3] = '{6, 8, 9, 10};

   ////////////////////////////////////////////////////////////////////////////////
   vdriver_level_select dut (
      .mclk(mclk), .reset_n(reset_n),
      .vphase_1(vp[1]), .vphase_2(vp[2]), .vphase_3(vp[3]), .vphase_4(vp[4]), .vphase_5(vp[5]),
      .vphase_6(vp[6]), .vphase_7(vp[7]), .vphase_8(vp[8]), .vphase_9(vp[9]), .vphase_10(vp[10]),
      .vphase_11(vp[11]), .vphase_12(vp[12]), .vphase_13(vp[13]),
      .sg_pulse_1(sg[1]), .sg_pulse_2(sg[2]), .sg_pulse_3(sg[3]), .sg_pulse_4(sg[4]),
      .sg_pulse_5(sg[5]), .sg_pulse_6(sg[6]), .sg_pulse_7(sg[7]), .sg_pulse_8(sg[8]),
      .substrate_clock_drive(sub_drv), .shutter_pulse_0(sp[0]), .shutter_pulse_1(sp[1]),
      .shutter_pulse_2(sp[2]), .shutter_pulse_3(sp[3]), .bias_pulse_0(bp[0]), .bias_pulse_1(bp[1]),
      .reg_wr_en(wr_en), .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
      .drv_out_1(d[0]), .drv_out_2(d[1]), .drv_out_3(d[2]), .drv_out_4(d[3]), .drv_out_5a(d[4]),
      .drv_out_5b(d[5]), .drv_out_6(d[6]), .drv_out_7a(d[7]), .drv_out_7b(d[8]), .drv_out_8(d[9]),
      .drv_out_9(d[10]), .drv_out_10(d[11]), .drv_out_11(d[12]), .drv_out_12(d[13]),
      .drv_out_13(d[14]), .substrate_clock_out(sub_out), .substrate_level_ctl(sub_ctl),
      .mech_shutter_out(mech), .strobe_out(strobe), .substrate_bias_sel(bias_sel)
   );

   always_comb begin
      for (int i = 0; i < 15; i++) begin
         codes[i] = d[i];
      end
      codes[15] = sub_out;
   end

   ccd_sensor_model sensor (.mclk(mclk), .codes(codes), .bad_codes(bad_codes));

   initial begin
      forever #50 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Inputs only move just after the falling edge, half a period clear of sampling.
   task automatic tick();
      @(negedge mclk);
   endtask

   task automatic write_reg(input logic [1:0] a, input logic [3:0] v);
      addr = a;
      wdata = v;
      wr_en = 1'b1;
      tick();
      wr_en = 1'b0;
      tick();
   endtask

   task automatic read_check(input logic [1:0] a, input logic [3:0] exp);
      addr = a;
      tick();
      check(rdata, exp);
   endtask

   function automatic logic [1:0] exp_level(input int c);
      if (vp[ph_of[c]]) return vdrv_pkg::LEVEL_LOW;
      if (gate_of[c] == 0 || sg[gate_of[c]]) return vdrv_pkg::LEVEL_MID;
      return vdrv_pkg::LEVEL_HIGH;
   endfunction

   function automatic logic shut_exp(input int c, input logic [5:0] k);
      if (c < 6) return k[c];
      if (c == 6) return k[0] ^ k[4];
      if (c == 7) return k[0] ^ k[5];
      if (c == 8) return k[0] ^ k[1];
      if (c == 9) return k[0] ^ k[2];
      return 1'b0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      reset_n = 1'b0;
      repeat (3) tick();
      for (int c = 0; c < 15; c++) begin
         check(d[c], vdrv_pkg::LEVEL_LOW);
      end
      check(sub_out, vdrv_pkg::LEVEL_HIGH);
      reset_n = 1'b1;
      repeat (3) tick();
      read_check(vdrv_pkg::ADDR_SUB_SRC, vdrv_pkg::SUB_SRC_RESET);
      read_check(vdrv_pkg::ADDR_MECH_SRC, vdrv_pkg::SHUT_SRC_RESET);
      read_check(vdrv_pkg::ADDR_STROBE_SRC, vdrv_pkg::SHUT_SRC_RESET);
      read_check(vdrv_pkg::ADDR_BIAS_SRC, vdrv_pkg::SHUT_SRC_RESET);
   endtask

   // Walking phases and gates catch a channel wired to its neighbour's pulse.
   task automatic test_vertical();
      for (int j = 0; j < 28; j++) begin
         vp = (j % 14 < 13) ? 13'h1 << (j % 14) : 13'h0;
         sg = (j < 14) ? 8'h1 << (j % 8) : ~(8'h1 << (j % 8));
         tick();
         for (int c = 0; c < 15; c++) begin
            check(d[c], exp_level(c));
         end
      end
   endtask

   // Every other source is held opposite, so a wrong code shows as the inverse.
   task automatic test_substrate();
      logic b;
      logic [13:1] tvp;
      logic [8:1] tsg;
      logic [3:0] tsp;
      write_reg(vdrv_pkg::ADDR_MECH_SRC, vdrv_pkg::SH_S0);
      write_reg(vdrv_pkg::ADDR_STROBE_SRC, vdrv_pkg::SH_S1);
      write_reg(vdrv_pkg::ADDR_BIAS_SRC, vdrv_pkg::SH_S2);
      for (int c = 0; c < 16; c++) begin
         write_reg(vdrv_pkg::ADDR_SUB_SRC, c[3:0]);
         read_check(vdrv_pkg::ADDR_SUB_SRC, c[3:0]);
         for (int v = 0; v < 3; v++) begin
            b = (v == 1);
            tvp = {13{~b}};
            tsg = {8{~b}};
            tsp = {4{~b}};
            if (c < 4) tvp[sub_ph[c]] = b;
            else if (c < 8) tsg[c + 1] = b;
            else if (c < 11) tsg[c - 6] = b;
            else if (c == 11) tsg[1] = b;
            else if (c == 12) tvp[13] = b;
            else if (c == 13) tsp[2] = b;
            else if (c == 14) tsp[0] = b;
            else tsp[1] = b;
            vp = tvp;
            sg = tsg;
            sp = tsp;
            bp = {2{~b}};
            sub_drv = (v < 2);
            tick();
            check(sub_ctl, b);
            check(sub_out, (v == 2) ? vdrv_pkg::LEVEL_HIGH : (b ? vdrv_pkg::LEVEL_LOW : vdrv_pkg::LEVEL_MID));
         end
      end
      sub_drv = 1'b0;
   endtask

   task automatic test_shutter();
      logic [5:0] k;
      for (int c = 0; c < 16; c++) begin
         write_reg(vdrv_pkg::ADDR_MECH_SRC, c[3:0]);
         write_reg(vdrv_pkg::ADDR_STROBE_SRC, 4'(c + 1));
         write_reg(vdrv_pkg::ADDR_BIAS_SRC, 4'(c + 2));
         for (int i = 0; i < 64; i++) begin
            k = i[5:0];
            sp = k[3:0];
            bp = k[5:4];
            tick();
            check(mech, shut_exp(c, k));
            check(strobe, shut_exp((c + 1) % 16, k));
            check(bias_sel, shut_exp((c + 2) % 16, k));
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8000) @(posedge mclk);
      n_errors++;
      print_verdict();
   end

   initial begin
      test_reset();
      write_reg(vdrv_pkg::ADDR_SUB_SRC, 4'h9);
      read_check(vdrv_pkg::ADDR_SUB_SRC, 4'h9);
      test_reset();
      test_vertical();
      test_substrate();
      test_shutter();
      check({3'h0, bad_codes != 0}, 4'h0);
      print_verdict();
   end
endmodule // vdriver_level_select_tb
`default_nettype wire
